// File: lmtwi_cfg.svh
`ifndef LMTWI_CFG_SVH
`define LMTWI_CFG_SVH

`define LMTWI_CLK_MHZ 125
`define LMTWI_DEV_ADDR 7'h50

`define LMTWI_T_STRETCH_US 500
`define LMTWI_T_NVWR_MS 80
`define LMTWI_T_VWR_MS 10
`define LMTWI_T_PAGE_MS 10
`define LMTWI_T_READY_MS 2000
`define LMTWI_T_RST_US 10
`define LMTWI_STRETCH_CYC 16'h0004

`define LMTWI_MAX_WORDS 3'h4
`define LMTWI_ADV_ADDR 8'h02
`define LMTWI_FLAG_ADDR 8'h09
`define LMTWI_CTRL_ADDR 8'h1A
`define LMTWI_MASK_ADDR 8'h20
`define LMTWI_PAGE_ADDR 8'h7F

`define LMTWI_FLAG_LOS 0
`define LMTWI_FLAG_FAULT 1
`define LMTWI_CTL_LDIS 0
`define LMTWI_CTL_LPM 4

`define LMTWI_APB_CTRL 12'h000
`define LMTWI_APB_STATUS 12'h004
`define LMTWI_APB_EVENT 12'h008
`define LMTWI_AC_PINDIS 0
`define LMTWI_EVT_MASK 8'hFC

`endif

// File: lmtwi_pkg.sv
`default_nettype none
package lmtwi_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_DEVA = 6'b000010,
        ST_MEMA = 6'b000100,
        ST_WR = 6'b001000,
        ST_RD = 6'b010000,
        ST_IGN = 6'b100000
    } lmtwi_state_t;
endpackage
`default_nettype wire

// File: lmtwi_sync.sv
`default_nettype none
module lmtwi_sync #(
    parameter int W = 7,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // a change is only taken once the last two stages agree
    for (genvar g = 0; g < W; g++) begin : g_bit
        logic s1_q, s2_q, s3_q, f_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_q <= INIT[g];
                s2_q <= INIT[g];
                s3_q <= INIT[g];
                f_q <= INIT[g];
            end else begin
                s1_q <= din[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    f_q <= s3_q;
                end
            end
        end
        assign dout[g] = f_q;
    end
endmodule
`default_nettype wire

// File: lmtwi_timer.sv
`default_nettype none
module lmtwi_timer #(
    parameter int unsigned START = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [31:0] value,
    output logic busy
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'(START);
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    assign busy = (cnt_q != 32'h0000_0000);
endmodule
`default_nettype wire

// File: lmtwi_mgmt_target.sv
`include "lmtwi_cfg.svh"
`default_nettype none
// Functional notes
// - answer only device address 1010000, last bit read or write.
// - act on no bus traffic unless module select is held low.
// - serial clock up to 400 kHz, optionally up to 1 MHz.
// - clock stretching never longer than 500 us.
// - on deselect abort and release both lines within 2 ms.
// - non-volatile writes complete within 80 ms.
// - volatile writes complete within 10 ms.
// - bank or page change takes effect within 10 ms.
// - acknowledge first transfer within 2000 ms of reset or power.
// - reset pin low at least 10 us resets the module.
// - low-power versus laser-disable pin mode switches within 100 ms.
// - interrupt line goes low within 200 ms of its condition.
// - flag condition sets its flag and interrupt within 200 ms.
// - laser fault sets fault flag and interrupt within 200 ms.
// - flags clear on read; interrupt releases within 500 us.
// - mask bit inhibits or restores interrupt within 100 ms.
// - laser disable bit drops optical output within 100 ms.
// - fast disable pin mode disables output within 3 ms.
// - clearing laser disable restores output within 400 ms.
// - address counter is last address plus one, kept between transfers.
// - address counter wraps inside the current 128-byte page.
// - up to 4 data words per write, committed only on stop.
// - no address acknowledge while an internal write is running.
// - repeated start inside a write discards that write.
module lmtwi_mgmt_target #(
    parameter int unsigned READY_CYC = `LMTWI_T_READY_MS * 1000 * `LMTWI_CLK_MHZ,
    parameter int unsigned NVWR_CYC = `LMTWI_T_NVWR_MS * 1000 * `LMTWI_CLK_MHZ,
    parameter int unsigned VWR_CYC = `LMTWI_T_VWR_MS * 1000 * `LMTWI_CLK_MHZ,
    parameter int unsigned PAGE_CYC = `LMTWI_T_PAGE_MS * 1000 * `LMTWI_CLK_MHZ,
    // value arbitrary: fast disable advertised to the host
    parameter logic FAST_DIS_ADV = 1'b1
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic MODULE_SELECT_N,
    input wire logic MODULE_RESET_N,
    input wire logic LOW_POWER_INPUT,
    input wire logic RECEIVE_SIGNAL_LOST,
    input wire logic LASER_FAULT_IN,
    output logic INTERRUPT_REQUEST_N,
    output logic LASER_ENABLE,
    output logic LOW_POWER_MODE
);
    localparam int unsigned RST_CYC = `LMTWI_T_RST_US * `LMTWI_CLK_MHZ;
    localparam int unsigned STRETCH_MAX = `LMTWI_T_STRETCH_US * `LMTWI_CLK_MHZ;

    logic [6:0] pin_f;
    logic scl_f, sda_f, sel_n_f, rstpin_f, lp_f, los_f, fault_f;
    logic scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det, sel;
    logic [10:0] rst_cnt_q;
    logic rst_hold;
    logic init_busy, wr_busy, match;
    lmtwi_pkg::lmtwi_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, addr_q, tx_q;
    logic [2:0] wr_len_q;
    logic [7:0] buf_a_q [0:3];
    logic [7:0] buf_d_q [0:3];
    logic commit_q, cor_q, sda_oe_q, scl_oe_q;
    logic [15:0] stretch_q;
    logic [7:0] mem_q [0:255];
    logic [7:0] ctrl_q, mask_q, page_q, flag_q, evt_q, set_vec;
    logic [31:0] wr_cyc;
    logic [1:0] apb_ctrl_q;
    logic irq_n_q, las_q, lpm_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // 8 ns sampling leaves ample margin at 1 MHz
    lmtwi_sync #(.W(7), .INIT(7'h0F)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .din({LASER_FAULT_IN, RECEIVE_SIGNAL_LOST, LOW_POWER_INPUT,
              MODULE_RESET_N, MODULE_SELECT_N, SDA_IN, SCL_IN}),
        .dout(pin_f)
    );

    assign scl_f = pin_f[0];
    assign sda_f = pin_f[1];
    assign sel_n_f = pin_f[2];
    assign rstpin_f = pin_f[3];
    assign lp_f = pin_f[4];
    assign los_f = pin_f[5];
    assign fault_f = pin_f[6];
    assign sel = ~sel_n_f;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;

    // short glitches on the reset pin are ignored
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_cnt_q <= 11'h000;
        end else if (rstpin_f) begin
            rst_cnt_q <= 11'h000;
        end else if (rst_cnt_q != 11'(RST_CYC)) begin
            rst_cnt_q <= rst_cnt_q + 11'h001;
        end
    end
    assign rst_hold = (rst_cnt_q == 11'(RST_CYC));

    // ready time restarts at the release of a reset pulse
    lmtwi_timer #(.START(READY_CYC)) u_init (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .load(rst_hold),
        .value(READY_CYC),
        .busy(init_busy)
    );

    lmtwi_timer #(.START(0)) u_wr (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .load(commit_q),
        .value(wr_cyc),
        .busy(wr_busy)
    );

    function automatic logic [7:0] nxt(input logic [7:0] a);
        nxt = {a[7], a[6:0] + 7'h01};
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        case (a)
            `LMTWI_ADV_ADDR: rd_byte = {7'h00, FAST_DIS_ADV};
            `LMTWI_FLAG_ADDR: rd_byte = flag_q;
            `LMTWI_CTRL_ADDR: rd_byte = ctrl_q;
            `LMTWI_MASK_ADDR: rd_byte = mask_q;
            `LMTWI_PAGE_ADDR: rd_byte = page_q;
            default: rd_byte = mem_q[a];
        endcase
    endfunction

    // busy or not yet ready: the address goes unanswered
    assign match = (sh_q[7:1] == `LMTWI_DEV_ADDR) && !init_busy && !wr_busy;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= lmtwi_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            addr_q <= 8'h00;
            tx_q <= 8'h00;
            wr_len_q <= 3'h0;
            commit_q <= 1'b0;
            cor_q <= 1'b0;
            sda_oe_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                buf_a_q[i] <= 8'h00;
                buf_d_q[i] <= 8'h00;
            end
        end else begin
            commit_q <= 1'b0;
            cor_q <= 1'b0;
            if (rst_hold || !sel) begin
                st_q <= lmtwi_pkg::ST_IDLE;
                cnt_q <= 4'h0;
                wr_len_q <= 3'h0;
                sda_oe_q <= 1'b0;
                if (rst_hold) begin
                    addr_q <= 8'h00;
                end
            end else if (start_det) begin
                st_q <= lmtwi_pkg::ST_DEVA;
                cnt_q <= 4'h0;
                wr_len_q <= 3'h0; // unstopped data dropped
                sda_oe_q <= 1'b0;
            end else if (stop_det) begin
                commit_q <= (st_q == lmtwi_pkg::ST_WR) && (wr_len_q != 3'h0);
                st_q <= lmtwi_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (cnt_q != 4'h8) begin
                    sh_q <= {sh_q[6:0], sda_f};
                    cnt_q <= cnt_q + 4'h1;
                end else begin
                    cnt_q <= 4'h0;
                    if (st_q == lmtwi_pkg::ST_DEVA) begin
                        st_q <= lmtwi_pkg::ST_RD;
                    end else if (st_q == lmtwi_pkg::ST_RD) begin
                        addr_q <= nxt(addr_q);
                        tx_q <= rd_byte(nxt(addr_q));
                        cor_q <= (addr_q == `LMTWI_FLAG_ADDR);
                        if (sda_f) begin
                            st_q <= lmtwi_pkg::ST_IGN;
                        end
                    end
                end
            end else if (scl_fall) begin
                sda_oe_q <= 1'b0;
                if (cnt_q == 4'h8) begin
                    case (st_q)
                        lmtwi_pkg::ST_DEVA: begin
                            if (match) begin
                                sda_oe_q <= 1'b1;
                                tx_q <= rd_byte(addr_q);
                                if (!sh_q[0]) begin
                                    st_q <= lmtwi_pkg::ST_MEMA;
                                end
                            end else begin
                                st_q <= lmtwi_pkg::ST_IGN;
                            end
                        end
                        lmtwi_pkg::ST_MEMA: begin
                            addr_q <= sh_q;
                            st_q <= lmtwi_pkg::ST_WR;
                            sda_oe_q <= 1'b1;
                        end
                        lmtwi_pkg::ST_WR: begin
                            if (wr_len_q != `LMTWI_MAX_WORDS) begin
                                buf_a_q[wr_len_q[1:0]] <= addr_q;
                                buf_d_q[wr_len_q[1:0]] <= sh_q;
                                wr_len_q <= wr_len_q + 3'h1;
                                addr_q <= nxt(addr_q);
                                sda_oe_q <= 1'b1;
                            end else begin
                                st_q <= lmtwi_pkg::ST_IGN;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (st_q == lmtwi_pkg::ST_RD) begin
                    sda_oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
                end
            end
        end
    end

    // hold the clock while the first read byte is fetched
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            stretch_q <= 16'h0000;
            scl_oe_q <= 1'b0;
        end else if (rst_hold || !sel) begin
            stretch_q <= 16'h0000;
            scl_oe_q <= 1'b0;
        end else if (scl_fall && cnt_q == 4'h8 && match && sh_q[0]
                     && st_q == lmtwi_pkg::ST_DEVA) begin
            stretch_q <= `LMTWI_STRETCH_CYC;
            scl_oe_q <= 1'b1;
        end else if (stretch_q != 16'h0000) begin
            stretch_q <= stretch_q - 16'h0001;
            scl_oe_q <= (stretch_q != 16'h0001);
        end
    end

    // data memory has no reset: contents survive a reset pulse
    always_ff @(posedge CLK_SYS) begin
        if (commit_q) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < wr_len_q) begin
                    mem_q[buf_a_q[i]] <= buf_d_q[i];
                end
            end
        end
    end

    // upper page is the non-volatile store, so it gets the long time
    always_comb begin
        logic nv, pg;
        nv = 1'b0;
        pg = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < wr_len_q) begin
                nv = nv | buf_a_q[i][7];
                pg = pg | (buf_a_q[i] == `LMTWI_PAGE_ADDR);
            end
        end
        if (nv) begin
            wr_cyc = NVWR_CYC;
        end else if (pg) begin
            wr_cyc = PAGE_CYC;
        end else begin
            wr_cyc = VWR_CYC;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= 8'h00;
            mask_q <= 8'h00;
            page_q <= 8'h00;
        end else if (rst_hold) begin
            ctrl_q <= 8'h00;
            mask_q <= 8'h00;
            page_q <= 8'h00;
        end else if (commit_q) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < wr_len_q) begin
                    case (buf_a_q[i])
                        `LMTWI_CTRL_ADDR: ctrl_q <= buf_d_q[i];
                        `LMTWI_MASK_ADDR: mask_q <= buf_d_q[i];
                        `LMTWI_PAGE_ADDR: page_q <= buf_d_q[i];
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    assign set_vec = {evt_q[7:2], fault_f, los_f};

    // a condition still present during the clearing read re-sets its flag
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            flag_q <= 8'h00;
        end else if (rst_hold) begin
            flag_q <= 8'h00;
        end else begin
            flag_q <= (cor_q ? 8'h00 : flag_q) | set_vec;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_n_q <= 1'b1;
            las_q <= 1'b0;
            lpm_q <= 1'b1;
        end else begin
            irq_n_q <= ~|(flag_q & ~mask_q);
            las_q <= ~(ctrl_q[`LMTWI_CTL_LDIS]
                       | (apb_ctrl_q[`LMTWI_AC_PINDIS] & lp_f));
            lpm_q <= ctrl_q[`LMTWI_CTL_LPM]
                     | (~apb_ctrl_q[`LMTWI_AC_PINDIS] & lp_f);
        end
    end

    // one-wait-state slave: answer one cycle into the access phase
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            apb_ctrl_q <= 2'h0;
            evt_q <= 8'h00;
        end else begin
            pready_q <= 1'b0;
            evt_q <= 8'h00;
            if (PSEL && PENABLE && !pready_q) begin
                pready_q <= 1'b1;
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
                case (PADDR)
                    `LMTWI_APB_CTRL: begin
                        if (PWRITE) begin
                            apb_ctrl_q <= PWDATA[1:0];
                        end else begin
                            prdata_q <= {30'h0000_0000, apb_ctrl_q};
                        end
                    end
                    `LMTWI_APB_STATUS: begin
                        if (!PWRITE) begin
                            prdata_q <= {20'h00000, las_q, wr_busy,
                                         ~init_busy, sel, flag_q};
                        end
                    end
                    `LMTWI_APB_EVENT: begin
                        if (PWRITE) begin
                            evt_q <= PWDATA[7:0] & `LMTWI_EVT_MASK;
                        end
                    end
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end else begin
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end
    end

    assign SCL_OE = scl_oe_q;
    assign SDA_OE = sda_oe_q;
    assign INTERRUPT_REQUEST_N = irq_n_q;
    assign LASER_ENABLE = las_q;
    assign LOW_POWER_MODE = lpm_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    a_foreign_addr: assert property (
        (st_q == lmtwi_pkg::ST_DEVA && scl_fall && cnt_q == 4'h8 && sel
         && !rst_hold && sh_q[7:1] != `LMTWI_DEV_ADDR)
        |=> !SDA_OE && st_q == lmtwi_pkg::ST_IGN)
        else $error("foreign address acknowledged");
    a_desel_release: assert property (
        (!sel) |=> !SDA_OE ##1 !SCL_OE && st_q == lmtwi_pkg::ST_IDLE)
        else $error("lines not released after deselect");
    a_busy_nack: assert property (
        (wr_busy && st_q == lmtwi_pkg::ST_DEVA && scl_fall && cnt_q == 4'h8)
        |=> !SDA_OE)
        else $error("address acknowledged during write cycle");
    a_init_nack: assert property (
        (init_busy && st_q == lmtwi_pkg::ST_DEVA && scl_fall
         && cnt_q == 4'h8) |=> !SDA_OE)
        else $error("address acknowledged before ready");
    a_page_wrap: assert property (
        (st_q != lmtwi_pkg::ST_MEMA && !rst_hold) |=> $stable(addr_q[7]))
        else $error("address counter crossed a page");
    a_flag_irq: assert property (
        (fault_f && !mask_q[`LMTWI_FLAG_FAULT] && !rst_hold)
        |=> flag_q[`LMTWI_FLAG_FAULT] ##1 !INTERRUPT_REQUEST_N)
        else $error("fault flag or interrupt late");
    a_cor_release: assert property (
        (cor_q && set_vec == 8'h00 && !rst_hold)
        |=> flag_q == 8'h00 ##1 INTERRUPT_REQUEST_N)
        else $error("interrupt not released after flag read");
    a_mask_gate: assert property (
        ((flag_q & ~mask_q) == 8'h00) |=> INTERRUPT_REQUEST_N)
        else $error("masked flag drives interrupt");
    a_laser_off: assert property (
        ctrl_q[`LMTWI_CTL_LDIS] |=> !LASER_ENABLE)
        else $error("laser not disabled by control bit");
    a_fast_dis: assert property (
        (apb_ctrl_q[`LMTWI_AC_PINDIS] && lp_f) |=> !LASER_ENABLE)
        else $error("fast disable pin ignored");
    a_word_limit: assert property (
        wr_len_q <= `LMTWI_MAX_WORDS)
        else $error("write buffer overrun");
    a_stretch_max: assert property (
        (32'(stretch_q) <= STRETCH_MAX) && (SCL_OE == (stretch_q != 16'h0000)))
        else $error("clock stretch out of bound");
    a_reset_pulse: assert property (
        (!rstpin_f && rst_cnt_q == 11'(RST_CYC - 1)) |=> rst_hold ##1 init_busy)
        else $error("reset pulse not honoured");
endmodule
`default_nettype wire

// File: lmtwi_host.sv
`default_nettype none
module lmtwi_host (
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // quarter steps of 31.25 ns: 125 ns serial clock, free of CLK_SYS
    initial begin
        scl_oe = 0;
        sda_oe = 0;
    end
    task automatic bit_x(input logic b, output logic r);
        int n;
        sda_oe = !b;
        #31.25 scl_oe = 0;
        n = 0;
        while (!scl && n < 9999) begin // target may stretch
            #8 n++;
        end
        #31.25 r = sda;
        #31.25 scl_oe = 1;
        #31.25;
    endtask
    task automatic start;
        sda_oe = 1;
        #31.25 scl_oe = 1;
        #31.25;
    endtask
    task automatic stop;
        sda_oe = 1;
        #31.25 scl_oe = 0;
        #31.25 sda_oe = 0;
        #31.25;
    endtask
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(mack, ak);
    endtask
endmodule
`default_nettype wire

// File: laser_module_twi_mgmt_target_tb.sv
`default_nettype none
module laser_module_twi_mgmt_target_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, sel_n = 1;
    logic lpi = 0, rsl = 0, flt = 0, irq_n, las, lpm, h_scl, h_sda, ak;
    logic mrst_n = 1;
    logic pready, pslverr, serr, scl_oe, sda_oe;
    logic [11:0] padr = 0;
    logic [31:0] pwd = 0, rd, prdata;
    logic [7:0] r, ptr;
    logic [7:0] mem [256];
    logic [7:0] wq [5];
    int err_count = 0, checked = 0;
    wire scl = !(scl_oe | h_scl);
    wire sda = !(sda_oe | h_sda);
    always #4 clk = ~clk;
    lmtwi_mgmt_target #(.READY_CYC(200), .NVWR_CYC(50), .VWR_CYC(50),
        .PAGE_CYC(50)) u_lmtwi_mgmt_target (.CLK_SYS(clk), .RSTN(rstn),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda),
        .SDA_OUT(), .SDA_OE(sda_oe), .MODULE_SELECT_N(sel_n),
        .MODULE_RESET_N(mrst_n), .LOW_POWER_INPUT(lpi),
        .RECEIVE_SIGNAL_LOST(rsl), .LASER_FAULT_IN(flt),
        .INTERRUPT_REQUEST_N(irq_n), .LASER_ENABLE(las),
        .LOW_POWER_MODE(lpm));
    lmtwi_host u_lmtwi_host (.scl(scl), .sda(sda), .scl_oe(h_scl),
        .sda_oe(h_sda));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bus free time between frames is the host's duty
    task automatic gap;
        #20us;
        @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(0, 1);
            end_of_test();
        end
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input int n);
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA0, 1, r, ak);
        chk(ak, 0);
        u_lmtwi_host.xfer(a, 1, r, ak);
        ptr = a;
        for (int i = 0; i < n; i++) begin
            u_lmtwi_host.xfer(wq[i], 1, r, ak);
            chk(ak, i > 3);
            // a refused fifth word voids the whole write
            if (n <= 4) mem[{a[7], a[6:0] + 7'(i)}] = wq[i];
        end
        u_lmtwi_host.stop();
    endtask
    task automatic rdn(input int n);
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA1, 1, r, ak);
        chk(ak, 0);
        for (int i = 0; i < n; i++) begin
            u_lmtwi_host.xfer(8'hFF, i == n - 1, r, ak);
            chk(r, mem[ptr]);
            ptr = {ptr[7], ptr[6:0] + 7'h01};
        end
        u_lmtwi_host.stop();
    endtask
    initial begin
        #600us;
        err_count++;
        end_of_test();
    end
    initial begin
        r = 8'($urandom(85322));
        repeat (10) @(posedge clk);
        rstn <= 1;
        repeat (300) @(posedge clk);
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA0, 1, r, ak);
        chk(ak, 1);
        u_lmtwi_host.stop();
        @(posedge clk);
        sel_n <= 0; // select setup shortened to one bus gap
        gap();
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA4, 1, r, ak);
        chk(ak, 1);
        u_lmtwi_host.stop();
        gap();
        $display("addressing test done");
        for (int i = 0; i < 5; i++) wq[i] = 8'($urandom);
        wr(8'hFE, 5);
        gap();
        wr(8'hFE, 4);
        apb(0, 12'h004, 0);
        chk(rd[10], 1);
        gap();
        wr(8'hFE, 0);
        gap();
        rdn(2);
        gap();
        rdn(2);
        gap();
        $display("memory test done");
        rsl <= 1;
        flt <= 1;
        repeat (10) @(posedge clk);
        chk(irq_n, 0);
        rsl <= 0;
        flt <= 0;
        wr(8'h09, 0);
        gap();
        mem[9] = 8'h03;
        rdn(1);
        gap();
        chk(irq_n, 1);
        wq[0] = 8'h01;
        wr(8'h20, 1);
        gap();
        rsl <= 1;
        repeat (10) @(posedge clk);
        chk(irq_n, 1);
        rsl <= 0;
        $display("flag test done");
        wr(8'h1A, 1);
        gap();
        chk(las, 0);
        wq[0] = 8'h00;
        wr(8'h1A, 1);
        gap();
        chk(las, 1);
        apb(1, 12'h000, 1);
        apb(0, 12'h000, 0);
        chk(rd, 1);
        lpi <= 1;
        repeat (10) @(posedge clk);
        chk(las, 0);
        apb(1, 12'h000, 0);
        repeat (10) @(posedge clk);
        chk(lpm, 1);
        apb(0, 12'h00C, 0);
        chk(serr, 1);
        lpi <= 0;
        $display("laser test done");
        gap();
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA1, 1, r, ak);
        @(posedge clk);
        sel_n <= 1;
        repeat (10) @(posedge clk);
        chk({scl_oe, sda_oe}, 0);
        u_lmtwi_host.stop();
        $display("abort test done");
        mrst_n <= 0;
        repeat (1400) @(posedge clk);
        mrst_n <= 1;
        apb(0, 12'h004, 0);
        chk(rd[9:0], 10'h000);
        sel_n <= 0;
        gap();
        u_lmtwi_host.start();
        u_lmtwi_host.xfer(8'hA1, 1, r, ak);
        chk(ak, 0);
        u_lmtwi_host.stop();
        $display("reset test done");
        end_of_test();
    end
endmodule
`default_nettype wire
